/* File: rtl/tku_pkg.sv */
package tku_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_CFG = 12'h000;
    localparam logic [11:0] ADDR_TIME_WIN = 12'h004;
    localparam logic [11:0] ADDR_ALARM_CFG = 12'h008;
    localparam logic [11:0] ADDR_ALARM_WIN = 12'h00c;
    // configuration / trim register fields
    localparam int CFG_TRIM_LSB = 0;
    localparam int CFG_PTR_LSB = 8;
    localparam int CFG_HALF_BIT = 11;
    localparam int CFG_WREN_BIT = 13;
    localparam int CFG_RUN_BIT = 15;
    localparam int ALARM_PTR_LSB = 8;
    // value field positions
    localparam int WEEKDAY_DIGIT_LSB = 8;
    localparam int HOUR_LSB = 0;
    localparam int MIN_LSB = 8;
    localparam int SEC_LSB = 0;
    localparam int MONTH_LSB = 8;
    localparam int DAY_LSB = 0;
    localparam int YEAR_LSB = 0;
    // window pointer codes
    localparam logic [1:0] PTR_MIN_SEC = 2'h0;
    localparam logic [1:0] PTR_WEEKDAY_DIGIT_HOUR = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
    localparam logic [1:0] PTR_YEAR = 2'h3;
    // reset values of control state
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [1:0] PTR_RST = 2'h0;
    localparam logic WREN_RST = 1'b0;
    localparam logic RUN_RST = 1'b0;
    // bcd wrap points
    localparam logic [6:0] SEC_LAST = 7'h59;
    localparam logic [6:0] MIN_LAST = 7'h59;
    localparam logic [5:0] HOUR_LAST = 6'h23;
    localparam logic [2:0] WEEKDAY_DIGIT_LAST = 3'h6;
    localparam logic [4:0] MONTH_LAST = 5'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [5:0] DAY_FIRST = 6'h01;
    localparam logic [4:0] MONTH_FIRST = 5'h01;
    // timekeeping pulse counts
    localparam int SEC_PULSES = 32768;
    localparam int HALF_PULSES = 16384;
    localparam int TRIM_STEP = 4;
    localparam logic [15:0] SEC_TERM = 16'(SEC_PULSES - 1);
    localparam logic [15:0] HALF_TERM = 16'(HALF_PULSES);
endpackage

/* File: rtl/tku_clock_trim.sv */
// Functional notes
// [R1] weekday is three bits 10-8, values 0-6, same in alarm weekday/hour
// [R2] hours are bcd: tens in bits 5-4 (0-2), units in bits 3-0
// [R3] minutes are bcd: tens in bits 14-12 (0-5), units in bits 11-8
// [R4] seconds are bcd: tens in bits 6-4 (0-5), units in bits 3-0
// [R5] alarm month/day: month tens bit 12, units 11-8, day tens 5-4, units 3-0
// [R6] unused bits of value registers read zero and ignore writes
// [R7] weekday/hour and alarm month/day, weekday/hour writes need write enable
// [R8] value fields have no reset value
// [R9] signed trim byte times four is added or subtracted once per minute
// [R10] positive trim adds pulses, negative trim removes pulses
// [R11] each trim step changes the correction by four pulses
// [R12] software writes trim only when stopped or just after a second edge
// [R13] 32768 timekeeping pulses make one nominal second
// [R14] time pointer picks min/sec, weekday_digit/hour, month/day, year; decrements to 00
// [R15] alarm pointer picks min/sec, weekday_digit/hour, month/day; decrements to 00
// [R16] trim spans +508 to -512 pulses per minute
// [R17] half-second flag clears on a write of the minute/second lower half
// [R18] fields count in bcd with carries up through weekday and day
// [R19] trim applies to the second after the minute boundary, no field skips
//
// The register offsets and the APB register port were chosen for this implementation.
module tku_clock_trim
    import tku_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rtc_clk_in,
    output logic half_second_flag,
    output logic clock_write_enable,
    output logic [7:0] clock_config_trim
);
    import tku_pkg::*;

    typedef struct packed {
        logic [1:0] sync;
        logic clk_prev;
        logic [15:0] pre;
        logic trim_due;
        logic half;
        logic [7:0] trim;
        logic [1:0] tptr;
        logic [1:0] aptr;
        logic wren;
        logic run;
        logic [31:0] rdata;
        logic err;
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [2:0] weekday_digit;
        logic [5:0] day;
        logic [4:0] month;
        logic [7:0] year;
        logic [6:0] asec;
        logic [6:0] amin;
        logic [5:0] ahour;
        logic [2:0] awday;
        logic [5:0] aday;
        logic [4:0] amonth;
    } tku_state_t;

    tku_state_t r;
    tku_state_t next_r;
    logic tick;
    logic sec_step;
    logic [15:0] limit;
    logic acc;
    logic wr;
    logic mapped;
    logic [15:0] time_rd;
    logic [15:0] alarm_rd;
    logic [31:0] rd_val;

    // one bcd step without wrap
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // last day of a bcd month, leap years by bcd year
    function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y);
        logic leap;
        leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
               (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
        case (m)
            5'h02: return leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
            default: return 6'h31;
        endcase
    endfunction

    // timekeeping pulse edge and trimmed second length
    assign tick = r.sync[1] & ~r.clk_prev;
    assign limit = r.trim_due ? SEC_TERM - 16'($signed(r.trim) * TRIM_STEP) : SEC_TERM; // R9 R10 R11 R16
    assign sec_step = tick & r.run & (r.pre == limit); // R13

    // apb strobes
    assign acc = psel & penable;
    assign wr = acc & pwrite & ~r.err;
    assign pready = 1'b1;
    assign pslverr = acc & r.err;
    assign prdata = r.rdata;
    assign half_second_flag = r.half;
    assign clock_write_enable = r.wren;
    assign clock_config_trim = r.trim;

    // window read values, unused bits zero
    always_comb begin
        time_rd = 16'h0000;
        alarm_rd = 16'h0000;
        case (r.tptr) // R14
            PTR_MIN_SEC: time_rd = (16'(r.min) << MIN_LSB) | (16'(r.sec) << SEC_LSB); // R3 R4 R6
            PTR_WEEKDAY_DIGIT_HOUR: time_rd = (16'(r.weekday_digit) << WEEKDAY_DIGIT_LSB) | (16'(r.hour) << HOUR_LSB); // R1 R2 R6
            PTR_MONTH_DAY: time_rd = (16'(r.month) << MONTH_LSB) | (16'(r.day) << DAY_LSB);
            default: time_rd = 16'(r.year) << YEAR_LSB;
        endcase
        case (r.aptr) // R15
            PTR_MIN_SEC: alarm_rd = (16'(r.amin) << MIN_LSB) | (16'(r.asec) << SEC_LSB);
            PTR_WEEKDAY_DIGIT_HOUR: alarm_rd = (16'(r.awday) << WEEKDAY_DIGIT_LSB) | (16'(r.ahour) << HOUR_LSB);
            PTR_MONTH_DAY: alarm_rd = (16'(r.amonth) << MONTH_LSB) | (16'(r.aday) << DAY_LSB); // R5
            default: alarm_rd = 16'h0000;
        endcase
    end

    // address decode for reads
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr == ADDR_CFG) begin
            rd_val = 32'(r.trim) << CFG_TRIM_LSB;
            rd_val[CFG_PTR_LSB +: 2] = r.tptr;
            rd_val[CFG_HALF_BIT] = r.half;
            rd_val[CFG_WREN_BIT] = r.wren;
            rd_val[CFG_RUN_BIT] = r.run;
        end else if (paddr == ADDR_TIME_WIN) begin
            rd_val = 32'(time_rd);
        end else if (paddr == ADDR_ALARM_CFG) begin
            rd_val[ALARM_PTR_LSB +: 2] = r.aptr;
        end else if (paddr == ADDR_ALARM_WIN) begin
            rd_val = 32'(alarm_rd);
        end else begin
            mapped = 1'b0;
        end
    end

    // next state: sync, count, bus writes
    always_comb begin
        next_r = r;
        next_r.sync = {r.sync[0], rtc_clk_in};
        next_r.clk_prev = r.sync[1];
        // setup phase captures read data and decode error
        if (psel && !penable) begin
            next_r.err = ~mapped;
            next_r.rdata = (mapped && !pwrite) ? rd_val : 32'h0000_0000;
        end
        // prescaler and trimmed second
        if (tick && r.run) begin
            next_r.pre = sec_step ? 16'h0000 : r.pre + 16'h0001;
        end
        // bcd carry chain
        if (sec_step) begin
            next_r.trim_due = 1'b0;
            if (r.sec == SEC_LAST) begin
                next_r.sec = 7'h00; // R18
                next_r.trim_due = 1'b1; // R19
                if (r.min == MIN_LAST) begin
                    next_r.min = 7'h00;
                    if (r.hour == HOUR_LAST) begin
                        next_r.hour = 6'h00;
                        next_r.weekday_digit = (r.weekday_digit == WEEKDAY_DIGIT_LAST) ? 3'h0 : r.weekday_digit + 3'h1; // R1 R18
                        if (r.day == last_day(r.month, r.year)) begin
                            next_r.day = DAY_FIRST;
                            if (r.month == MONTH_LAST) begin
                                next_r.month = MONTH_FIRST;
                                next_r.year = (r.year == YEAR_LAST) ? 8'h00 : bcd_inc(r.year);
                            end else begin
                                next_r.month = 5'(bcd_inc(8'(r.month)));
                            end
                        end else begin
                            next_r.day = 6'(bcd_inc(8'(r.day)));
                        end
                    end else begin
                        next_r.hour = 6'(bcd_inc(8'(r.hour))); // R2
                    end
                end else begin
                    next_r.min = 7'(bcd_inc(8'(r.min))); // R3
                end
            end else begin
                next_r.sec = 7'(bcd_inc(8'(r.sec))); // R4
            end
        end
        // configuration writes
        if (wr && paddr == ADDR_CFG) begin
            if (pstrb[0]) begin
                next_r.trim = pwdata[CFG_TRIM_LSB +: 8]; // R9
            end
            if (pstrb[1]) begin
                next_r.tptr = pwdata[CFG_PTR_LSB +: 2];
                next_r.wren = pwdata[CFG_WREN_BIT];
                if (r.wren) begin
                    next_r.run = pwdata[CFG_RUN_BIT];
                end
            end
        end
        if (wr && paddr == ADDR_ALARM_CFG && pstrb[1]) begin
            next_r.aptr = pwdata[ALARM_PTR_LSB +: 2];
        end
        // time window writes, software wins over counting
        if (wr && paddr == ADDR_TIME_WIN) begin
            case (r.tptr)
                PTR_MIN_SEC: begin
                    if (pstrb[1]) begin
                        next_r.min = pwdata[MIN_LSB +: 7]; // R3 R6
                    end
                    if (pstrb[0]) begin
                        next_r.sec = pwdata[SEC_LSB +: 7]; // R4 R6
                        next_r.pre = 16'h0000; // R17
                    end
                end
                PTR_WEEKDAY_DIGIT_HOUR: begin
                    if (r.wren && pstrb[1]) begin
                        next_r.weekday_digit = pwdata[WEEKDAY_DIGIT_LSB +: 3]; // R1 R7
                    end
                    if (r.wren && pstrb[0]) begin
                        next_r.hour = pwdata[HOUR_LSB +: 6]; // R2 R7
                    end
                end
                PTR_MONTH_DAY: begin
                    if (r.wren && pstrb[1]) begin
                        next_r.month = pwdata[MONTH_LSB +: 5];
                    end
                    if (r.wren && pstrb[0]) begin
                        next_r.day = pwdata[DAY_LSB +: 6];
                    end
                end
                default: begin
                    if (r.wren && pstrb[0]) begin
                        next_r.year = pwdata[YEAR_LSB +: 8];
                    end
                end
            endcase
        end
        // alarm window writes
        if (wr && paddr == ADDR_ALARM_WIN) begin
            case (r.aptr)
                PTR_MIN_SEC: begin
                    if (pstrb[1]) begin
                        next_r.amin = pwdata[MIN_LSB +: 7];
                    end
                    if (pstrb[0]) begin
                        next_r.asec = pwdata[SEC_LSB +: 7];
                    end
                end
                PTR_WEEKDAY_DIGIT_HOUR: begin
                    if (r.wren && pstrb[1]) begin
                        next_r.awday = pwdata[WEEKDAY_DIGIT_LSB +: 3]; // R7
                    end
                    if (r.wren && pstrb[0]) begin
                        next_r.ahour = pwdata[HOUR_LSB +: 6]; // R7
                    end
                end
                PTR_MONTH_DAY: begin
                    if (r.wren && pstrb[1]) begin
                        next_r.amonth = pwdata[MONTH_LSB +: 5]; // R5 R7
                    end
                    if (r.wren && pstrb[0]) begin
                        next_r.aday = pwdata[DAY_LSB +: 6]; // R5 R7
                    end
                end
                default: begin
                end
            endcase
        end
        // window pointers step down on upper-half access
        if (acc && !r.err && paddr == ADDR_TIME_WIN && (!pwrite || pstrb[1]) && r.tptr != 2'h0) begin
            next_r.tptr = r.tptr - 2'h1; // R14
        end
        if (acc && !r.err && paddr == ADDR_ALARM_WIN && (!pwrite || pstrb[1]) && r.aptr != 2'h0) begin
            next_r.aptr = r.aptr - 2'h1; // R15
        end
        next_r.half = (next_r.pre >= HALF_TERM); // R17
    end

    // state register, value fields left without reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.sync <= 2'b00;
            r.clk_prev <= 1'b0;
            r.pre <= 16'h0000;
            r.trim_due <= 1'b0;
            r.half <= 1'b0;
            r.trim <= TRIM_RST;
            r.tptr <= PTR_RST;
            r.aptr <= PTR_RST;
            r.wren <= WREN_RST;
            r.run <= RUN_RST;
            r.rdata <= 32'h0000_0000;
            r.err <= 1'b0; // R8
        end else begin
            r <= next_r;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wdhr_locked: assert property ( // R7
        (wr && paddr == ADDR_TIME_WIN && r.tptr == PTR_WEEKDAY_DIGIT_HOUR && !r.wren && !sec_step)
        |=> $stable(r.weekday_digit) && $stable(r.hour)) else $error("weekday/hour changed while locked");
    a_amd_locked: assert property ((wr && paddr == ADDR_ALARM_WIN && r.aptr == PTR_MONTH_DAY && !r.wren) // R7
        |=> $stable(r.amonth) && $stable(r.aday)) else $error("alarm month/day changed while locked");
    a_unused_zero: assert property ( // R6
        (psel && !penable && !pwrite && paddr == ADDR_TIME_WIN && r.tptr == PTR_WEEKDAY_DIGIT_HOUR)
        |=> prdata[31:11] == 21'h0 && prdata[7:6] == 2'b00) else $error("unused bits not zero");
    a_half_clear: assert property ((wr && paddr == ADDR_TIME_WIN && r.tptr == PTR_MIN_SEC && pstrb[0]) // R17
        |=> !half_second_flag && r.pre == 16'h0000) else $error("half flag not cleared");
    a_tptr_step: assert property ((acc && !r.err && !pwrite && paddr == ADDR_TIME_WIN && r.tptr != 2'h0) // R14
        |=> r.tptr == $past(r.tptr) - 2'h1) else $error("time pointer did not step");
    a_aptr_floor: assert property ((acc && !r.err && !pwrite && paddr == ADDR_ALARM_WIN && r.aptr == 2'h0) // R15
        |=> r.aptr == 2'h0) else $error("alarm pointer went below zero");
    a_trim_len: assert property ((sec_step && r.trim_due) // R11 R16
        |-> r.pre >= 16'h7e03 && r.pre <= 16'h81ff && r.pre == SEC_TERM - 16'($signed(r.trim) * TRIM_STEP))
        else $error("trimmed second has wrong length");
    a_plain_len: assert property ((sec_step && !r.trim_due) |-> r.pre == SEC_TERM) // R13
        else $error("untrimmed second not 32768 pulses");
    a_min_wrap: assert property ((sec_step && r.sec == 7'h59 && !(wr && paddr == ADDR_TIME_WIN)) // R18 R19
        |=> r.sec == 7'h00 && r.trim_due && r.min != $past(r.min)) else $error("minute carry wrong");
    a_weekday_digit_wrap: assert property ((sec_step && r.sec == 7'h59 && r.min == 7'h59 && r.hour == 6'h23 && // R1 R18
        r.weekday_digit == 3'h6 && !(wr && paddr == ADDR_TIME_WIN)) |=> r.weekday_digit == 3'h0 && r.hour == 6'h00)
        else $error("weekday did not wrap");
    a_stopped: assert property ((!r.run && !(wr && paddr == ADDR_TIME_WIN)) |=> $stable(r.pre)) // R13
        else $error("prescaler moved while stopped");

    c_trim_pos: cover property (sec_step && r.trim_due && !r.trim[7] && r.trim != 8'h00);
    c_trim_neg: cover property (sec_step && r.trim_due && r.trim[7]);
    c_weekday_digit_wrap: cover property (sec_step && r.hour == 6'h23 && r.min == 7'h59 && r.sec == 7'h59 && r.weekday_digit == 3'h6);
    c_locked_write: cover property (wr && paddr == ADDR_TIME_WIN && r.tptr == PTR_WEEKDAY_DIGIT_HOUR && !r.wren);
endmodule

/* File: verification/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tku_pkg::*;

    localparam logic [15:0] WH_MASK = 16'h073f;
    localparam logic [15:0] MS_MASK = 16'h7f7f;
    localparam logic [15:0] MD_MASK = 16'h1f3f;
    localparam int CYCLE_LIMIT = 75000;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rtc_clk_in = 1'b0;
    logic half_second_flag;
    logic clock_write_enable;
    logic [7:0] clock_config_trim;
    logic [32:0] exp_q[$];
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] whv, msv, mdv, awv, amv, ms2, yrv;
    int m;
    logic [7:0] trims[5];

    tku_clock_trim dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rtc_clk_in(rtc_clk_in), .half_second_flag(half_second_flag),
        .clock_write_enable(clock_write_enable), .clock_config_trim(clock_config_trim)
    );

    // 25 mhz bus clock, timekeeping pin at two bus clocks per pulse so a second fits the run
    always #20 pclk = ~pclk;
    always #40 rtc_clk_in = ~rtc_clk_in;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction

    // expected configuration word from its fields
    function automatic logic [31:0] cfgv(input logic run, input logic wren, input logic [1:0] ptr,
                                         input logic [7:0] trim);
        return (32'(run) << CFG_RUN_BIT) | (32'(wren) << CFG_WREN_BIT) | (32'(ptr) << CFG_PTR_LSB) | 32'(trim);
    endfunction

    // one apb transfer, request held until pready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(1'b1, a, d, s);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        exp_q.push_back({err, exp});
        xfer(1'b0, a, 32'h0, 4'h0);
    endtask

    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // read results compared against the oldest note
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0)
                check(33'h0, 33'h1, "read with no note");
            else
                check({pslverr, prdata}, exp_q.pop_front(), "read data");
        end
    end

    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            mismatches++;
            $display("MISMATCH t=%0t timeout", $time);
            final_report();
        end
    end

    initial begin
        void'($urandom(5));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset state, run bit refused without prior write enable
        check(33'(clock_write_enable), 33'h0, "wren at reset");
        check(33'(clock_config_trim), 33'h0, "trim at reset");
        rd(ADDR_CFG, 32'h0, 1'b0);
        wr(ADDR_CFG, cfgv(1'b1, 1'b0, 2'h0, 8'h00), 4'b0011);
        rd(ADDR_CFG, 32'h0, 1'b0);
        idle();
        $display("test reset_state done");
        // trim codes at both ends, unit steps and a random one
        trims = '{8'h7f, 8'h80, 8'hff, 8'h01, 8'($urandom)};
        foreach (trims[i]) begin
            wr(ADDR_CFG, 32'(trims[i]), 4'b0001);
            rd(ADDR_CFG, cfgv(1'b0, 1'b0, 2'h0, trims[i]), 1'b0);
            check(33'(clock_config_trim), 33'(trims[i]), "trim mirror");
        end
        wr(ADDR_CFG, 32'h0, 4'b0001);
        idle();
        $display("test trim_codes done");
        // time window: pointer steps, masked unused bits, write protection
        whv = {5'h0, 3'($urandom % 7), 2'h0, 6'(bcd($urandom % 24))};
        msv = {1'b0, 7'(bcd($urandom % 60)), 1'b0, 7'(bcd($urandom % 60))};
        ms2 = {1'b0, 7'(bcd($urandom % 60)), 1'b0, 7'(bcd($urandom % 60))};
        mdv = {3'h0, 5'(bcd(1 + $urandom % 12)), 2'h0, 6'(bcd(1 + $urandom % 31))};
        yrv = {8'h00, bcd($urandom % 100)};
        wr(ADDR_CFG, cfgv(1'b0, 1'b1, PTR_WEEKDAY_DIGIT_HOUR, 8'h00), 4'b0011);
        wr(ADDR_TIME_WIN, {16'hffff, whv | ~WH_MASK}, 4'b0011);
        wr(ADDR_TIME_WIN, {16'hffff, msv | ~MS_MASK}, 4'b0011);
        check(33'(clock_write_enable), 33'h1, "wren mirror");
        wr(ADDR_CFG, cfgv(1'b0, 1'b1, PTR_WEEKDAY_DIGIT_HOUR, 8'h00), 4'b0011);
        rd(ADDR_TIME_WIN, 32'(whv), 1'b0);
        rd(ADDR_TIME_WIN, 32'(msv), 1'b0);
        rd(ADDR_CFG, cfgv(1'b0, 1'b1, PTR_MIN_SEC, 8'h00), 1'b0);
        // year and month/day through the top pointer codes
        wr(ADDR_CFG, cfgv(1'b0, 1'b1, PTR_YEAR, 8'h00), 4'b0011);
        wr(ADDR_TIME_WIN, {16'hffff, 8'hff, yrv[7:0]}, 4'b0011);
        wr(ADDR_TIME_WIN, {16'hffff, mdv | ~MD_MASK}, 4'b0011);
        wr(ADDR_CFG, cfgv(1'b0, 1'b1, PTR_YEAR, 8'h00), 4'b0011);
        rd(ADDR_TIME_WIN, 32'(yrv), 1'b0);
        rd(ADDR_TIME_WIN, 32'(mdv), 1'b0);
        wr(ADDR_CFG, cfgv(1'b0, 1'b0, PTR_WEEKDAY_DIGIT_HOUR, 8'h00), 4'b0011);
        wr(ADDR_TIME_WIN, 32'h0, 4'b0011);
        wr(ADDR_TIME_WIN, 32'(ms2), 4'b0011);
        wr(ADDR_CFG, cfgv(1'b0, 1'b0, PTR_WEEKDAY_DIGIT_HOUR, 8'h00), 4'b0011);
        rd(ADDR_TIME_WIN, 32'(whv), 1'b0);
        rd(ADDR_TIME_WIN, 32'(ms2), 1'b0);
        idle();
        $display("test time_window done");
        // alarm window from month/day down to minutes/seconds
        awv = {5'h0, 3'($urandom % 7), 2'h0, 6'(bcd($urandom % 24))};
        amv = {1'b0, 7'(bcd($urandom % 60)), 1'b0, 7'(bcd($urandom % 60))};
        wr(ADDR_CFG, cfgv(1'b0, 1'b1, 2'h0, 8'h00), 4'b0011);
        wr(ADDR_ALARM_CFG, 32'(PTR_MONTH_DAY) << ALARM_PTR_LSB, 4'b0010);
        wr(ADDR_ALARM_WIN, {16'hffff, mdv | ~MD_MASK}, 4'b0011);
        wr(ADDR_ALARM_WIN, {16'hffff, awv | ~WH_MASK}, 4'b0011);
        wr(ADDR_ALARM_WIN, {16'hffff, amv | ~MS_MASK}, 4'b0011);
        wr(ADDR_ALARM_CFG, 32'(PTR_MONTH_DAY) << ALARM_PTR_LSB, 4'b0010);
        rd(ADDR_ALARM_WIN, 32'(mdv), 1'b0);
        rd(ADDR_ALARM_WIN, 32'(awv), 1'b0);
        rd(ADDR_ALARM_WIN, 32'(amv), 1'b0);
        rd(ADDR_ALARM_CFG, 32'h0, 1'b0);
        wr(ADDR_ALARM_CFG, 32'(PTR_YEAR) << ALARM_PTR_LSB, 4'b0010);
        rd(ADDR_ALARM_WIN, 32'h0, 1'b0);
        rd(ADDR_ALARM_WIN, 32'(mdv), 1'b0);
        wr(ADDR_CFG, 32'h0, 4'b0011);
        wr(ADDR_ALARM_CFG, 32'(PTR_MONTH_DAY) << ALARM_PTR_LSB, 4'b0010);
        wr(ADDR_ALARM_WIN, 32'h0, 4'b0011);
        wr(ADDR_ALARM_WIN, 32'h0, 4'b0011);
        wr(ADDR_ALARM_CFG, 32'(PTR_MONTH_DAY) << ALARM_PTR_LSB, 4'b0010);
        rd(ADDR_ALARM_WIN, 32'(mdv), 1'b0);
        rd(ADDR_ALARM_WIN, 32'(awv), 1'b0);
        idle();
        $display("test alarm_window done");
        // unmapped places answer with an error and no effect
        rd(12'h010, 32'h0, 1'b1);
        wr(12'hffc, 32'hffff_ffff, 4'b1111);
        rd(12'hffc, 32'h0, 1'b1);
        rd(ADDR_CFG, 32'h0, 1'b0);
        idle();
        $display("test unmapped done");
        // running well short of one nominal second leaves the time alone
        wr(ADDR_CFG, cfgv(1'b0, 1'b1, 2'h0, 8'h00), 4'b0011);
        wr(ADDR_CFG, cfgv(1'b1, 1'b1, 2'h0, 8'h00), 4'b0011);
        idle();
        repeat (1800) @(posedge pclk);
        check(33'(half_second_flag), 33'h0, "half flag early");
        rd(ADDR_CFG, cfgv(1'b1, 1'b1, 2'h0, 8'h00), 1'b0);
        rd(ADDR_TIME_WIN, 32'(ms2), 1'b0);
        idle();
        $display("test short_run done");
        // one whole second from a fresh prescaler, seconds carry into minutes
        m = $urandom % 59;
        wr(ADDR_TIME_WIN, 32'({1'b0, 7'(bcd(m)), 8'h59}), 4'b0011);
        idle();
        repeat (40000) @(posedge pclk);
        check(33'(half_second_flag), 33'h1, "half flag in second half");
        repeat (25390) @(posedge pclk);
        rd(ADDR_TIME_WIN, {17'h0, 7'(bcd(m)), 8'h59}, 1'b0);
        idle();
        repeat (200) @(posedge pclk);
        rd(ADDR_TIME_WIN, {17'h0, 7'(bcd(m + 1)), 8'h00}, 1'b0);
        check(33'(half_second_flag), 33'h0, "half flag after second");
        idle();
        $display("test full_second done");
        repeat (3) @(posedge pclk);
        check(33'(exp_q.size()), 33'h0, "notes left");
        final_report();
    end
endmodule
